/* src/vector_dispatch_pkg.sv */
// Purpose: shared constants and state type for the vector dispatch unit
// Assumes: 16-bit words, 20-bit physical addresses, segment shifted by four bits
// Notes: vector numbers are eight bits wide
package vector_dispatch_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int ADDR_W = 20;
  localparam int VEC_W = 8;
  // ----------------------------------------------------------------
  // fixed vector types
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_DIVIDE = 8'h00;
  localparam logic [7:0] VEC_STEP = 8'h01;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] VEC_BOUND = 8'h05;
  localparam logic [7:0] VEC_UNDEF = 8'h06;
  localparam logic [7:0] VEC_ESCAPE = 8'h07;
  localparam logic [7:0] VEC_RESERVED_LAST = 8'h1F;
  // ----------------------------------------------------------------
  // escape opcode range D8..DF: top five bits match
  // ----------------------------------------------------------------
  localparam logic [7:0] ESC_OPCODE_BASE = 8'hD8;
  localparam logic [7:0] ESC_OPCODE_MASK = 8'hF8;
  // ----------------------------------------------------------------
  // status word bits and address arithmetic
  // ----------------------------------------------------------------
  localparam int FLAG_IF = 9;
  localparam int FLAG_TF = 8;
  localparam int VEC_SCALE_SHIFT = 2;
  localparam int SEG_SHIFT = 4;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [19:0] TABLE_BASE = 20'h00000;
  localparam logic [19:0] TABLE_CS_OFFSET = 20'h00002;
  // ----------------------------------------------------------------
  // dispatch sequence
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACK, ST_PUSH_FLAGS, ST_PUSH_CS, ST_PUSH_IP, ST_LOAD_IP, ST_LOAD_CS, ST_FINISH
  } dispatch_state_e;
endpackage

/* src/mem_step_if.sv */
// Purpose: one word access request between sequencer and memory port
// Assumes: single clock domain
// Notes: start is a one-cycle pulse, done answers it once
`timescale 1ns/100ps
`default_nettype none
interface mem_step_if;
  logic start;
  logic write;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport issuer (output start, output write, output addr, output wdata,
                  input done, input rdata);
  modport worker (input start, input write, input addr, input wdata,
                  output done, output rdata);
endinterface
`default_nettype wire

/* src/mem_word_port.sv */
// Purpose: runs one word read or write on the core memory port
// Assumes: memory answers with mem_ack_i on the same clock
// Notes: a start while a request is open is ignored
`timescale 1ns/100ps
`default_nettype none
module mem_word_port (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // sequencer side
  mem_step_if.worker step,
  // memory side
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [19:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i
);
  wire accept = step.start & ~mem_req_o;
  wire finish = mem_req_o & mem_ack_i;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_req_o <= 1'h0;
      mem_we_o <= 1'h0;
      mem_addr_o <= 20'h00000;
      mem_wdata_o <= 16'h0000;
      step.done <= 1'h0;
      step.rdata <= 16'h0000;
    end else begin
      step.done <= finish;
      if (accept) begin
        mem_req_o <= 1'h1;
        mem_we_o <= step.write;
        mem_addr_o <= step.addr;
        mem_wdata_o <= step.wdata;
      end else if (finish) begin
        mem_req_o <= 1'h0;
        step.rdata <= mem_rdata_i;
      end
    end
  end
endmodule
`default_nettype wire

/* src/vector_dispatch.sv */
// Purpose: interrupt and exception dispatch, stack save and vector fetch
// Assumes: core stalls while busy_o is high and pulses insn_end_i per instruction
// Notes: the core loads new_* when dispatch_done_o pulses
//
// Behaviour
// [RL1] push status word, code segment, instruction pointer
// [RL2] table of up to 256 pointer entries
// [RL3] enter via indirect call at type times four
// [RL4] types 0 through 31 reserved
// [RL5] eight-bit vector type selects table entry
// [RL6] internal vectors for exceptions and controller requests
// [RL7] external logic supplies vector during acknowledge
// [RL8] non-maskable request uses internal type 2
// [RL9] hardware requests sampled at instruction boundaries only
// [RL10] nested hardware requests accepted when re-enabled
// [RL11] escape trap returns to opcode or prefix
// [RL12] other exceptions return to following instruction
// [RL13] divide quotient overflow raises type 0
// [RL14] software interrupt carries any of 256 types
// [RL15] table at zero, offset word then segment
// [RL16] response clears the interrupt-enable flag
// [RL17] escape opcodes raise type 7 when enabled
// [RL18] single step raises type 1, with exceptions
`timescale 1ns/100ps
`default_nettype none
module vector_dispatch (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // instruction boundary from the execution unit
  input wire logic insn_end_i,
  input wire logic [15:0] insn_ip_i,
  input wire logic [15:0] prefix_ip_i,
  input wire logic seg_prefix_i,
  input wire logic [15:0] next_ip_i,
  input wire logic [7:0] opcode_i,
  input wire logic [15:0] cs_i,
  input wire logic [15:0] ss_i,
  input wire logic [15:0] sp_i,
  input wire logic [15:0] flags_i,
  input wire logic step_inhibit_i,
  // exception and software interrupt causes
  input wire logic div_overflow_i,
  input wire logic into_overflow_i,
  input wire logic bound_fail_i,
  input wire logic undef_opcode_i,
  input wire logic escape_trap_en_i,
  input wire logic sw_int_i,
  input wire logic [7:0] sw_type_i,
  // hardware requests
  input wire logic nmi_i,
  input wire logic ctl_req_i,
  input wire logic [7:0] ctl_vec_i,
  input wire logic ctl_cascade_i,
  input wire logic ack_valid_i,
  input wire logic [7:0] ack_vector_i,
  // memory port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [19:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // results
  output logic busy_o,
  output logic inta_o,
  output logic ctl_taken_o,
  output logic reserved_use_o,
  output logic dispatch_done_o,
  output logic [7:0] vector_type_o,
  output logic [15:0] new_cs_o,
  output logic [15:0] new_ip_o,
  output logic [15:0] new_flags_o,
  output logic [15:0] new_sp_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] off);
    phys = (20'(seg) << vector_dispatch_pkg::SEG_SHIFT) + 20'(off);
  endfunction

  function automatic logic [19:0] table_addr(input logic [7:0] vtype);
    table_addr = vector_dispatch_pkg::TABLE_BASE +
                 (20'(vtype) << vector_dispatch_pkg::VEC_SCALE_SHIFT); // [RL3] [RL15]
  endfunction

  function automatic logic reserved_type(input logic [7:0] vtype);
    reserved_type = vtype <= vector_dispatch_pkg::VEC_RESERVED_LAST;
  endfunction

  mem_step_if step ();

  mem_word_port u_port (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .step(step.worker),
    .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i)
  );

  // ----------------------------------------------------------------
  // non-maskable input: three flops, edge latched until serviced
  // ----------------------------------------------------------------
  logic nmi_s1, nmi_s2, nmi_s3, nmi_level, nmi_pend;
  wire nmi_stable = nmi_s2 == nmi_s3;
  wire nmi_rise = nmi_stable & nmi_s2 & ~nmi_level;

  // ----------------------------------------------------------------
  // boundary decision
  // ----------------------------------------------------------------
  vector_dispatch_pkg::dispatch_state_e state;
  logic issued;
  logic [7:0] vtype;
  logic [15:0] ret_ip, ret_cs, saved_flags, sp, ss, load_ip;

  wire is_escape = (opcode_i & vector_dispatch_pkg::ESC_OPCODE_MASK) ==
                   vector_dispatch_pkg::ESC_OPCODE_BASE;
  wire esc_hit = escape_trap_en_i & is_escape; // [RL17]
  wire exc_hit = div_overflow_i | into_overflow_i | bound_fail_i | undef_opcode_i | esc_hit;
  wire int_enabled = flags_i[vector_dispatch_pkg::FLAG_IF];
  // hardware sources only looked at here, once per instruction end
  wire boundary = insn_end_i & (state == vector_dispatch_pkg::ST_IDLE); // [RL9]
  wire take_sw = exc_hit | sw_int_i; // [RL9] own-instruction causes win
  wire take_nmi = ~take_sw & nmi_pend;
  wire take_ctl = ~take_sw & ~nmi_pend & ctl_req_i & int_enabled; // [RL10]
  wire take_step = ~take_sw & ~nmi_pend & ~take_ctl &
                   flags_i[vector_dispatch_pkg::FLAG_TF] & ~step_inhibit_i; // [RL18]
  wire take_any = take_sw | take_nmi | take_ctl | take_step;

  // internally generated types, divide first as it cannot coexist with others
  wire [7:0] exc_type = div_overflow_i ? vector_dispatch_pkg::VEC_DIVIDE : // [RL13]
                        esc_hit ? vector_dispatch_pkg::VEC_ESCAPE :
                        undef_opcode_i ? vector_dispatch_pkg::VEC_UNDEF :
                        bound_fail_i ? vector_dispatch_pkg::VEC_BOUND :
                        vector_dispatch_pkg::VEC_OVERFLOW; // [RL6]
  wire [7:0] pick_type = exc_hit ? exc_type :
                         sw_int_i ? sw_type_i : // [RL14]
                         take_nmi ? vector_dispatch_pkg::VEC_NMI : // [RL8]
                         take_ctl ? ctl_vec_i : // [RL6]
                         vector_dispatch_pkg::VEC_STEP; // [RL18]
  wire [15:0] esc_ret = seg_prefix_i ? prefix_ip_i : insn_ip_i; // [RL11]
  wire [15:0] pick_ret = esc_hit ? esc_ret : next_ip_i; // [RL12]
  wire ext_vector = take_ctl & ctl_cascade_i;

  // ----------------------------------------------------------------
  // memory step data per state
  // ----------------------------------------------------------------
  wire [15:0] sp_dec = sp - vector_dispatch_pkg::STACK_STEP;
  wire is_push = state == vector_dispatch_pkg::ST_PUSH_FLAGS ||
                 state == vector_dispatch_pkg::ST_PUSH_CS ||
                 state == vector_dispatch_pkg::ST_PUSH_IP;
  wire is_load = state == vector_dispatch_pkg::ST_LOAD_IP ||
                 state == vector_dispatch_pkg::ST_LOAD_CS;
  wire [15:0] push_data = (state == vector_dispatch_pkg::ST_PUSH_FLAGS) ? saved_flags :
                          (state == vector_dispatch_pkg::ST_PUSH_CS) ? ret_cs : ret_ip; // [RL1]
  wire [19:0] load_addr = (state == vector_dispatch_pkg::ST_LOAD_IP) ? table_addr(vtype) :
                          table_addr(vtype) + vector_dispatch_pkg::TABLE_CS_OFFSET; // [RL15]
  wire [19:0] step_addr = is_push ? phys(ss, sp_dec) : load_addr;
  wire step_go = (is_push | is_load) & ~issued;
  wire step_end = (is_push | is_load) & issued & step.done;
  wire [15:0] cleared_flags = saved_flags &
                              ~(16'h0001 << vector_dispatch_pkg::FLAG_IF) &
                              ~(16'h0001 << vector_dispatch_pkg::FLAG_TF); // [RL16]

  vector_dispatch_pkg::dispatch_state_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      vector_dispatch_pkg::ST_IDLE: begin
        if (boundary & take_any) begin
          next_state = ext_vector ? vector_dispatch_pkg::ST_ACK :
                                    vector_dispatch_pkg::ST_PUSH_FLAGS;
        end
      end
      vector_dispatch_pkg::ST_ACK: begin
        if (ack_valid_i) begin
          next_state = vector_dispatch_pkg::ST_PUSH_FLAGS;
        end
      end
      vector_dispatch_pkg::ST_PUSH_FLAGS: begin
        if (step_end) next_state = vector_dispatch_pkg::ST_PUSH_CS;
      end
      vector_dispatch_pkg::ST_PUSH_CS: begin
        if (step_end) next_state = vector_dispatch_pkg::ST_PUSH_IP;
      end
      vector_dispatch_pkg::ST_PUSH_IP: begin
        if (step_end) next_state = vector_dispatch_pkg::ST_LOAD_IP;
      end
      vector_dispatch_pkg::ST_LOAD_IP: begin
        if (step_end) next_state = vector_dispatch_pkg::ST_LOAD_CS;
      end
      vector_dispatch_pkg::ST_LOAD_CS: begin
        if (step_end) next_state = vector_dispatch_pkg::ST_FINISH;
      end
      vector_dispatch_pkg::ST_FINISH: begin
        next_state = vector_dispatch_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state and non-maskable latch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nmi_s1 <= 1'h0;
      nmi_s2 <= 1'h0;
      nmi_s3 <= 1'h0;
      nmi_level <= 1'h0;
      nmi_pend <= 1'h0;
      state <= vector_dispatch_pkg::ST_IDLE;
      issued <= 1'h0;
    end else begin
      nmi_s1 <= nmi_i;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
      if (nmi_stable) nmi_level <= nmi_s2;
      // a new edge in the take cycle stays pending
      nmi_pend <= nmi_rise | (nmi_pend & ~(boundary & take_nmi)); // [RL8]
      state <= next_state;
      issued <= step_end ? 1'h0 : (issued | step_go);
    end
  end

  // ----------------------------------------------------------------
  // captured context and memory step issue
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vtype <= 8'h00;
      ret_ip <= 16'h0000;
      ret_cs <= 16'h0000;
      saved_flags <= 16'h0000;
      sp <= 16'h0000;
      ss <= 16'h0000;
      load_ip <= 16'h0000;
      step.start <= 1'h0;
      step.write <= 1'h0;
      step.addr <= 20'h00000;
      step.wdata <= 16'h0000;
    end else begin
      step.start <= step_go;
      if (boundary & take_any) begin
        vtype <= pick_type; // [RL5]
        ret_ip <= pick_ret;
        ret_cs <= cs_i;
        saved_flags <= flags_i; // saved copy keeps the old enable state
        sp <= sp_i;
        ss <= ss_i;
      end
      if (state == vector_dispatch_pkg::ST_ACK && ack_valid_i) begin
        vtype <= ack_vector_i; // [RL7]
      end
      if (step_go) begin
        step.write <= is_push;
        step.addr <= step_addr; // [RL2]
        step.wdata <= push_data; // [RL1]
      end
      if (step_end & is_push) sp <= sp_dec; // [RL1]
      if (step_end && state == vector_dispatch_pkg::ST_LOAD_IP) load_ip <= step.rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'h0;
      inta_o <= 1'h0;
      ctl_taken_o <= 1'h0;
      reserved_use_o <= 1'h0;
      dispatch_done_o <= 1'h0;
      vector_type_o <= 8'h00;
      new_cs_o <= 16'h0000;
      new_ip_o <= 16'h0000;
      new_flags_o <= 16'h0000;
      new_sp_o <= 16'h0000;
    end else begin
      busy_o <= next_state != vector_dispatch_pkg::ST_IDLE;
      inta_o <= next_state == vector_dispatch_pkg::ST_ACK;
      ctl_taken_o <= boundary & take_ctl;
      // only an acknowledge vector comes from outside; controller vectors are our own
      reserved_use_o <= state == vector_dispatch_pkg::ST_ACK & ack_valid_i &
                        reserved_type(ack_vector_i); // [RL4]
      dispatch_done_o <= state == vector_dispatch_pkg::ST_FINISH;
      if (state == vector_dispatch_pkg::ST_FINISH) begin
        vector_type_o <= vtype;
        new_ip_o <= load_ip; // [RL3]
        new_flags_o <= cleared_flags; // [RL16]
        new_sp_o <= sp;
      end
      if (step_end && state == vector_dispatch_pkg::ST_LOAD_CS) new_cs_o <= step.rdata;
    end
  end
endmodule
`default_nettype wire

/* tb/vector_dispatch_assertions.sv */
// Purpose: concurrent checks on the ports of the vector dispatch unit
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound from the testbench file
`timescale 1ns/100ps
`default_nettype none
module vector_dispatch_assertions (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // causes
  input wire logic insn_end_i,
  input wire logic div_overflow_i,
  input wire logic ack_valid_i,
  input wire logic mem_ack_i,
  // outputs watched
  input wire logic busy_o,
  input wire logic inta_o,
  input wire logic ctl_taken_o,
  input wire logic reserved_use_o,
  input wire logic dispatch_done_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [19:0] mem_addr_o,
  input wire logic [7:0] vector_type_o,
  input wire logic [15:0] new_flags_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_req_hold: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request dropped or changed before ack");
  chk_div_vector: assert property (
    insn_end_i && !busy_o && div_overflow_i |-> ##[2:300] (dispatch_done_o && vector_type_o == 8'h00))
    else $error("divide overflow did not dispatch type 0");
  chk_done_flags: assert property (
    dispatch_done_o |-> new_flags_o[9] == 1'b0 && new_flags_o[8] == 1'b0)
    else $error("new status word keeps enable or step bit");
  chk_done_busy: assert property (
    dispatch_done_o |-> !busy_o && $past(busy_o))
    else $error("done not aligned with end of busy");
  chk_done_pulse: assert property (
    dispatch_done_o |=> !dispatch_done_o)
    else $error("done longer than one cycle");
  chk_table_read: assert property (
    mem_req_o && !mem_we_o |-> mem_addr_o[19:10] == 10'h000 && !mem_addr_o[0])
    else $error("vector read outside table");
  chk_idle_quiet: assert property (
    !busy_o |-> !mem_req_o && !inta_o)
    else $error("bus activity while idle");
  chk_inta_drop: assert property (
    inta_o && ack_valid_i |=> !inta_o)
    else $error("acknowledge not closed after vector");
  chk_ctl_taken: assert property (
    ctl_taken_o |-> busy_o)
    else $error("controller taken outside a dispatch");
  chk_res_pulse: assert property (
    reserved_use_o |=> !reserved_use_o)
    else $error("reserved warning longer than one cycle");
  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  cov_escape: cover property (dispatch_done_o && vector_type_o == 8'h07);
  cov_ack: cover property (inta_o && ack_valid_i);
  cov_taken: cover property (ctl_taken_o);
endmodule
`default_nettype wire

/* tb/far_side_model.sv */
// Purpose: memory and external acknowledge partner of the dispatch unit
// Assumes: table word at an address is the address xor 5A5A
// Notes: wait_i gives extra cycles before each memory ack
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // memory side
  input wire logic mem_req_i,
  input wire logic [19:0] mem_addr_i,
  input wire logic [1:0] wait_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o,
  // acknowledge side
  input wire logic inta_i,
  input wire logic [7:0] vec_i,
  output logic ack_valid_o,
  output logic [7:0] ack_vector_o
);
  logic [1:0] cnt;
  logic [1:0] ack_st;
  // released data toggles so a stale value never looks valid
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 2'h0;
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 16'hFFFF;
    end else begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
        if (cnt == wait_i) begin
          mem_ack_o <= 1'b1;
          mem_rdata_o <= mem_addr_i[15:0] ^ 16'h5A5A;
          cnt <= 2'h0;
        end else begin
          cnt <= cnt + 2'h1;
        end
      end
    end
  end
  // one eight-bit vector per acknowledge window
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_st <= 2'h0;
      ack_valid_o <= 1'b0;
      ack_vector_o <= 8'h00;
    end else begin
      ack_valid_o <= 1'b0;
      ack_vector_o <= ~ack_vector_o;
      if (!inta_i) begin
        ack_st <= 2'h0;
      end else if (ack_st == 2'h0) begin
        ack_st <= 2'h1;
      end else if (ack_st == 2'h1) begin
        ack_st <= 2'h2;
        ack_valid_o <= 1'b1;
        ack_vector_o <= vec_i;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: self-checking bench for the vector dispatch unit
// Assumes: far_side_model serves memory and acknowledge cycles
// Notes: outputs are sampled on the falling edge to stay clear of updates
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, insn_end_i = 1'b0, seg_prefix_i = 1'b0;
  logic step_inhibit_i = 1'b0, div_overflow_i = 1'b0, into_overflow_i = 1'b0;
  logic bound_fail_i = 1'b0, undef_opcode_i = 1'b0, escape_trap_en_i = 1'b0, sw_int_i = 1'b0;
  logic nmi_i = 1'b0, ctl_req_i = 1'b0, ctl_cascade_i = 1'b0;
  logic [15:0] insn_ip_i = 16'h0040, prefix_ip_i = 16'h003F, next_ip_i = 16'h0043;
  logic [15:0] cs_i = 16'h1234, ss_i = 16'h0800, sp_i = 16'h0100, flags_i = 16'h0202;
  logic [7:0] opcode_i = 8'h90, sw_type_i = 8'h00, ctl_vec_i = 8'h00, cas_vec = 8'h00;
  logic [1:0] mem_wait = 2'h0;
  logic ack_valid_i, mem_req_o, mem_we_o, mem_ack_i, busy_o, inta_o;
  logic ctl_taken_o, reserved_use_o, dispatch_done_o;
  logic [7:0] ack_vector_i, vector_type_o;
  logic [19:0] mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata_i, new_cs_o, new_ip_o, new_flags_o, new_sp_o;
  int num_errors = 0, n_tests = 0, acc_n = 0;
  logic [19:0] acc_a [0:7];
  logic [15:0] acc_d [0:7];
  logic seen_taken = 1'b0, seen_res = 1'b0;
  vector_dispatch u_dut (.*);
  far_side_model u_far (.core_clk_i, .nrst_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .wait_i(mem_wait), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i), .inta_i(inta_o),
    .vec_i(cas_vec), .ack_valid_o(ack_valid_i), .ack_vector_o(ack_vector_i));
  always #4 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) begin
    if (ctl_taken_o) seen_taken = 1'b1;
    if (reserved_use_o) seen_res = 1'b1;
    if (mem_req_o && mem_ack_i && acc_n < 8) begin
      acc_a[acc_n] = mem_addr_o;
      acc_d[acc_n] = mem_we_o ? mem_wdata_o : mem_rdata_i;
      acc_n++;
    end
  end
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one instruction boundary; hit says whether a dispatch must follow
  task automatic boundary(input logic hit, input logic [7:0] vt, input logic [15:0] ret);
    int n;
    logic [19:0] ea [0:4];
    logic [15:0] ed [0:4];
    n = 0;
    acc_n = 0;
    seen_taken = 1'b0;
    seen_res = 1'b0;
    insn_end_i <= 1'b1;
    @(posedge core_clk_i);
    {insn_end_i, div_overflow_i, into_overflow_i, bound_fail_i, undef_opcode_i} <= 5'h00;
    sw_int_i <= 1'b0;
    while (dispatch_done_o !== 1'b1 && n < (hit ? 400 : 12)) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("done", {19'h00000, hit}, {19'h00000, dispatch_done_o});
    chk("accesses", hit ? 20'h00005 : 20'h00000, 20'(acc_n));
    if (hit) begin
      ea[0] = {ss_i, 4'h0} + {4'h0, sp_i - 16'h0002};
      ea[1] = {ss_i, 4'h0} + {4'h0, sp_i - 16'h0004};
      ea[2] = {ss_i, 4'h0} + {4'h0, sp_i - 16'h0006};
      ea[3] = {10'h000, vt, 2'h0};
      ea[4] = ea[3] + 20'h00002;
      ed = '{flags_i, cs_i, ret, ea[3][15:0] ^ 16'h5A5A, ea[4][15:0] ^ 16'h5A5A};
      for (int k = 0; k < 5; k++) begin
        chk("access address", ea[k], acc_a[k]);
        chk("access data", {4'h0, ed[k]}, {4'h0, acc_d[k]});
      end
      chk("vector", {12'h000, vt}, {12'h000, vector_type_o});
      chk("new ip", {4'h0, ed[3]}, {4'h0, new_ip_o});
      chk("new cs", {4'h0, ed[4]}, {4'h0, new_cs_o});
      chk("new flags", {4'h0, flags_i & 16'hFCFF}, {4'h0, new_flags_o});
      chk("new sp", {4'h0, sp_i - 16'h0006}, {4'h0, new_sp_o});
    end
    @(posedge core_clk_i);
  endtask
  task automatic t_exceptions;
    logic [7:0] vt [0:3];
    vt = '{8'h00, 8'h04, 8'h05, 8'h06};
    flags_i <= 16'h0302;
    sp_i <= 16'h0004;
    for (int i = 0; i < 4; i++) begin
      mem_wait <= i[1:0];
      {div_overflow_i, into_overflow_i, bound_fail_i, undef_opcode_i} <= 4'h8 >> i;
      boundary(1'b1, vt[i], 16'h0043);
    end
    $display("test exceptions finished");
  endtask
  task automatic t_escape;
    flags_i <= 16'h0202;
    sp_i <= 16'h0100;
    mem_wait <= 2'h0;
    escape_trap_en_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      opcode_i <= 8'hD8 + i[7:0];
      seg_prefix_i <= i[0];
      boundary(1'b1, 8'h07, i[0] ? 16'h003F : 16'h0040);
    end
    opcode_i <= 8'hE0;
    boundary(1'b0, 8'h00, 16'h0000);
    opcode_i <= 8'hD8;
    escape_trap_en_i <= 1'b0;
    boundary(1'b0, 8'h00, 16'h0000);
    opcode_i <= 8'h90;
    seg_prefix_i <= 1'b0;
    $display("test escape finished");
  endtask
  task automatic t_software;
    logic [7:0] ty [0:2];
    ty = '{8'h03, 8'h20, 8'hFF};
    ctl_req_i <= 1'b1;
    ctl_vec_i <= 8'h0D;
    for (int i = 0; i < 3; i++) begin
      sw_int_i <= 1'b1;
      sw_type_i <= ty[i];
      boundary(1'b1, ty[i], 16'h0043);
      chk("taken early", 20'h00000, {19'h00000, seen_taken});
    end
    boundary(1'b1, 8'h0D, 16'h0043);
    chk("taken", 20'h00001, {19'h00000, seen_taken});
    chk("reserved use", 20'h00000, {19'h00000, seen_res});
    ctl_req_i <= 1'b0;
    $display("test software finished");
  endtask
  task automatic t_controller;
    flags_i <= 16'h0002;
    ctl_req_i <= 1'b1;
    ctl_cascade_i <= 1'b1;
    boundary(1'b0, 8'h00, 16'h0000);
    flags_i <= 16'h0202;
    cas_vec <= 8'h10;
    boundary(1'b1, 8'h10, 16'h0043);
    chk("reserved use", 20'h00001, {19'h00000, seen_res});
    cas_vec <= 8'h40;
    boundary(1'b1, 8'h40, 16'h0043);
    chk("reserved use", 20'h00000, {19'h00000, seen_res});
    ctl_req_i <= 1'b0;
    ctl_cascade_i <= 1'b0;
    $display("test controller finished");
  endtask
  task automatic t_nmi_step;
    flags_i <= 16'h0102;
    step_inhibit_i <= 1'b1;
    nmi_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    boundary(1'b1, 8'h02, 16'h0043);
    nmi_i <= 1'b0;
    boundary(1'b0, 8'h00, 16'h0000);
    step_inhibit_i <= 1'b0;
    boundary(1'b1, 8'h01, 16'h0043);
    flags_i <= 16'h0202;
    $display("test nmi and step finished");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    t_exceptions();
    t_escape();
    t_software();
    t_controller();
    t_nmi_step();
    wrap_up();
  end
  // about twenty dispatches of under a hundred cycles each
  initial begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    wrap_up();
  end
endmodule
bind vector_dispatch vector_dispatch_assertions u_chk (.*);
`default_nettype wire
